//--- shared/rrs_pkg.sv
// Constants and types for the return, rotate and subtract execution unit
// Contract
// - Plain return pops stack top into program counter, two instruction cycles.
// - Literal return loads its 8-bit immediate, 0 to 255, into working register.
// - Literal return also reloads program counter from stack top; one word, two cycles.
// - Rotate left: old carry into bit 0, old bit 7 becomes carry.
// - Rotate left destination 0 writes working register, 1 writes file register.
// - Rotate right: old carry into bit 7, old bit 0 becomes carry.
// - Rotate right destination 0 writes working register, 1 writes file register.
// - Subtract from literal: literal minus working register, stored in working register.
// - Carry and digit carry clear when working register exceeds literal, per width.
package rrs_pkg;
	localparam int RRS_DATA_W = 8;
	localparam int RRS_PC_W   = 15;
	localparam int RRS_FADR_W = 7;
	localparam int RRS_NIB_HI = 3;
	localparam int RRS_MSB    = 7;
	localparam logic [7:0] RRS_W_RST    = 8'h00;
	localparam logic [7:0] RRS_ZERO8    = 8'h00;
	localparam logic [1:0] RRS_RET_CYC  = 2'h2;
	localparam logic       RRS_DEST_W   = 1'h0;
	localparam logic       RRS_DEST_F   = 1'h1;

	// Instruction selector presented with each issue strobe
	typedef enum logic [2:0] {
		RRS_OP_NONE,
		RRS_OP_RETURN,
		RRS_OP_LITERAL_RETURN,
		RRS_OP_ROTATE_LEFT,
		RRS_OP_ROTATE_RIGHT,
		RRS_OP_LITERAL_MINUS_WORK
	} rrs_op_t;
endpackage

//--- rtl/rrs_status_reg.sv
// Status flag holder: carry, digit carry and zero with per-flag write enables
module rrs_status_reg
	import rrs_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	// Flag updates
	input  wire logic c_we_i,
	input  wire logic c_i,
	input  wire logic dc_we_i,
	input  wire logic dc_i,
	input  wire logic z_we_i,
	input  wire logic z_i,
	// Flag state
	output logic      c_o,
	output logic      dc_o,
	output logic      z_o
);
	logic c_next;
	logic dc_next;
	logic z_next;

	// Flags without a write enable hold their value
	always_comb begin
		c_next  = c_we_i  ? c_i  : c_o;
		dc_next = dc_we_i ? dc_i : dc_o;
		z_next  = z_we_i  ? z_i  : z_o;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			c_o  <= 1'b0;
			dc_o <= 1'b0;
			z_o  <= 1'b0;
		end else begin
			c_o  <= c_next;
			dc_o <= dc_next;
			z_o  <= z_next;
		end
	end
endmodule

//--- rtl/rrs_exec.sv
// Execution unit for return, literal return, rotates through carry and subtract from literal
module rrs_exec
	import rrs_pkg::*;
(
	// Clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rstn_i,
	// Instruction issue
	input  wire logic                  issue_i,
	input  wire rrs_op_t               op_i,
	input  wire logic [RRS_DATA_W-1:0] literal_i,
	input  wire logic                  dest_sel_i,
	input  wire logic [RRS_FADR_W-1:0] file_addr_i,
	// File register read data and stack top
	input  wire logic [RRS_DATA_W-1:0] file_rdata_i,
	input  wire logic [RRS_PC_W-1:0]   stack_top_entry_i,
	// Core state
	output logic [RRS_DATA_W-1:0]      work_o,
	output logic                       carry_o,
	output logic                       digit_carry_flag_o,
	output logic                       zero_o,
	// File register write back
	output logic                       file_we_o,
	output logic [RRS_FADR_W-1:0]      file_waddr_o,
	output logic [RRS_DATA_W-1:0]      file_wdata_o,
	// Program flow
	output logic                       stack_pop_o,
	output logic                       pc_load_o,
	output logic [RRS_PC_W-1:0]        pc_o,
	output logic                       busy_o,
	output logic                       done_o
);
	typedef enum logic {
		RRS_ST_IDLE,
		RRS_ST_RET2
	} rrs_state_t;

	rrs_state_t            state_reg, state_next;
	logic [RRS_DATA_W-1:0] work_reg, work_next;
	logic                  fwe_reg, fwe_next;
	logic [RRS_FADR_W-1:0] fadr_reg, fadr_next;
	logic [RRS_DATA_W-1:0] fdat_reg, fdat_next;
	logic                  pop_reg, pop_next;
	logic                  pcld_reg, pcld_next;
	logic [RRS_PC_W-1:0]   pc_reg, pc_next;
	logic                  done_reg, done_next;
	logic                  busy_reg, busy_next;
	logic                  c_we, c_new, dc_we, dc_new, z_we, z_new;
	logic [RRS_DATA_W-1:0] rot_res;
	logic [RRS_DATA_W-1:0] diff;
	logic                  c_cur, dc_cur, z_cur;

	// Unsigned no-borrow test, shared by carry and digit carry
	function automatic logic not_above(input logic [RRS_DATA_W-1:0] w, input logic [RRS_DATA_W-1:0] k);
		not_above = (w <= k);
	endfunction

	// Next state of the execution sequencer and all result registers
	always_comb begin
		state_next = state_reg;
		work_next  = work_reg;
		fwe_next   = 1'b0;
		fadr_next  = fadr_reg;
		fdat_next  = fdat_reg;
		pop_next   = 1'b0;
		pcld_next  = 1'b0;
		pc_next    = pc_reg;
		done_next  = 1'b0;
		busy_next  = 1'b0;
		c_we       = 1'b0;
		c_new      = c_cur;
		dc_we      = 1'b0;
		dc_new     = dc_cur;
		z_we       = 1'b0;
		z_new      = z_cur;
		rot_res    = RRS_ZERO8;
		diff       = literal_i - work_reg;
		unique case (state_reg)
			RRS_ST_IDLE: begin
				if (issue_i) begin
					unique case (op_i)
						RRS_OP_RETURN: begin
							pop_next   = 1'b1;
							pcld_next  = 1'b1;
							pc_next    = stack_top_entry_i;
							state_next = RRS_ST_RET2;
							busy_next  = 1'b1;
						end
						RRS_OP_LITERAL_RETURN: begin
							work_next  = literal_i;
							pop_next   = 1'b1;
							pcld_next  = 1'b1;
							pc_next    = stack_top_entry_i;
							state_next = RRS_ST_RET2;
							busy_next  = 1'b1;
						end
						RRS_OP_ROTATE_LEFT: begin
							rot_res = {file_rdata_i[RRS_MSB-1:0], c_cur};
							c_we    = 1'b1;
							c_new   = file_rdata_i[RRS_MSB];
							if (dest_sel_i == RRS_DEST_F) begin
								fwe_next  = 1'b1;
								fadr_next = file_addr_i;
								fdat_next = rot_res;
							end else begin
								work_next = rot_res;
							end
							done_next = 1'b1;
						end
						RRS_OP_ROTATE_RIGHT: begin
							rot_res = {c_cur, file_rdata_i[RRS_MSB:1]};
							c_we    = 1'b1;
							c_new   = file_rdata_i[0];
							if (dest_sel_i == RRS_DEST_F) begin
								fwe_next  = 1'b1;
								fadr_next = file_addr_i;
								fdat_next = rot_res;
							end else begin
								work_next = rot_res;
							end
							done_next = 1'b1;
						end
						RRS_OP_LITERAL_MINUS_WORK: begin
							work_next = diff;
							c_we   = 1'b1;
							c_new  = not_above(work_reg, literal_i);
							dc_we  = 1'b1;
							dc_new = not_above({{(RRS_DATA_W-RRS_NIB_HI-1){1'b0}}, work_reg[RRS_NIB_HI:0]},
								{{(RRS_DATA_W-RRS_NIB_HI-1){1'b0}}, literal_i[RRS_NIB_HI:0]});
							z_we  = 1'b1;
							z_new = (diff == RRS_ZERO8);
							done_next = 1'b1;
						end
						default: begin
							done_next = 1'b0;
						end
					endcase
				end
			end
			RRS_ST_RET2: begin
				// Second return cycle; issue is ignored here as the pipe refetches
				state_next = RRS_ST_IDLE;
				done_next  = 1'b1;
			end
		endcase
	end

	// Result and sequencer registers
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= RRS_ST_IDLE;
			work_reg  <= RRS_W_RST;
			fwe_reg   <= 1'b0;
			fadr_reg  <= '0;
			fdat_reg  <= RRS_ZERO8;
			pop_reg   <= 1'b0;
			pcld_reg  <= 1'b0;
			pc_reg    <= '0;
			done_reg  <= 1'b0;
			busy_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			work_reg  <= work_next;
			fwe_reg   <= fwe_next;
			fadr_reg  <= fadr_next;
			fdat_reg  <= fdat_next;
			pop_reg   <= pop_next;
			pcld_reg  <= pcld_next;
			pc_reg    <= pc_next;
			done_reg  <= done_next;
			busy_reg  <= busy_next;
		end
	end

	// Status flags; each op raises only the enables of the flags it owns, so rotates leave digit carry and zero alone
	rrs_status_reg u_status (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.c_we_i    (c_we),
		.c_i       (c_new),
		.dc_we_i   (dc_we),
		.dc_i      (dc_new),
		.z_we_i    (z_we),
		.z_i       (z_new),
		.c_o       (c_cur),
		.dc_o      (dc_cur),
		.z_o       (z_cur)
	);

	// Outputs straight from flip-flops
	assign work_o             = work_reg;
	assign carry_o            = c_cur;
	assign digit_carry_flag_o = dc_cur;
	assign zero_o             = z_cur;
	assign file_we_o          = fwe_reg;
	assign file_waddr_o       = fadr_reg;
	assign file_wdata_o       = fdat_reg;
	assign stack_pop_o        = pop_reg;
	assign pc_load_o          = pcld_reg;
	assign pc_o               = pc_reg;
	assign busy_o             = busy_reg;
	assign done_o             = done_reg;
endmodule

//--- tb/rrs_exec_sva.sv
// Checker for the return, rotate and subtract unit ports
module rrs_exec_sva
	import rrs_pkg::*;
(
	// Clock and reset
	input wire logic                  ref_clk_i,
	input wire logic                  rstn_i,
	// Issue side
	input wire logic                  issue_i,
	input wire rrs_op_t               op_i,
	input wire logic [RRS_DATA_W-1:0] literal_i,
	input wire logic                  dest_sel_i,
	input wire logic [RRS_DATA_W-1:0] file_rdata_i,
	input wire logic [RRS_PC_W-1:0]   stack_top_entry_i,
	// Results
	input wire logic [RRS_DATA_W-1:0] work_o,
	input wire logic                  carry_o,
	input wire logic                  digit_carry_flag_o,
	input wire logic                  zero_o,
	input wire logic                  file_we_o,
	input wire logic [RRS_DATA_W-1:0] file_wdata_o,
	input wire logic                  stack_pop_o,
	input wire logic                  pc_load_o,
	input wire logic [RRS_PC_W-1:0]   pc_o,
	input wire logic                  busy_o,
	input wire logic                  done_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// Expected results from the values seen at the issue edge
	wire       tk  = issue_i && !busy_o;
	wire [7:0] rl  = {file_rdata_i[6:0], carry_o};
	wire [7:0] rr  = {carry_o, file_rdata_i[7:1]};
	wire [7:0] df  = literal_i - work_o;
	wire       cy  = work_o <= literal_i;
	wire       dcy = work_o[3:0] <= literal_i[3:0];
	sequence s_tk(rrs_op_t o); tk && op_i == o; endsequence
	sequence s_pop; stack_pop_o && pc_load_o && busy_o && pc_o == $past(stack_top_entry_i); endsequence
	sequence s_end; done_o && !busy_o; endsequence
	a_ret_pop: assert property (s_tk(RRS_OP_RETURN) |=> s_pop ##1 s_end)
		else $error("plain return pop or timing wrong");
	a_lit_work: assert property (s_tk(RRS_OP_LITERAL_RETURN) |=> work_o == $past(literal_i))
		else $error("literal return work value wrong");
	a_lit_pc: assert property (s_tk(RRS_OP_LITERAL_RETURN) |=> s_pop ##1 s_end)
		else $error("literal return pop or timing wrong");
	a_rl_res: assert property (s_tk(RRS_OP_ROTATE_LEFT) |=> carry_o == $past(file_rdata_i[7]) &&
		($past(dest_sel_i) ? file_we_o && file_wdata_o == $past(rl) : !file_we_o && work_o == $past(rl)))
		else $error("rotate left result wrong");
	a_rr_res: assert property (s_tk(RRS_OP_ROTATE_RIGHT) |=> carry_o == $past(file_rdata_i[0]) &&
		($past(dest_sel_i) ? file_we_o && file_wdata_o == $past(rr) : !file_we_o && work_o == $past(rr)))
		else $error("rotate right result wrong");
	a_sub_val: assert property (s_tk(RRS_OP_LITERAL_MINUS_WORK) |=> work_o == $past(df))
		else $error("subtract difference wrong");
	a_sub_flag: assert property (s_tk(RRS_OP_LITERAL_MINUS_WORK) |=> carry_o == $past(cy) &&
		digit_carry_flag_o == $past(dcy)) else $error("subtract carry flags wrong");
	a_sub_zero: assert property (s_tk(RRS_OP_LITERAL_MINUS_WORK) |=> zero_o == (work_o == 8'h00))
		else $error("subtract zero flag wrong");
	a_one_cyc: assert property (tk && op_i inside {RRS_OP_ROTATE_LEFT, RRS_OP_ROTATE_RIGHT,
		RRS_OP_LITERAL_MINUS_WORK} |=> s_end) else $error("single cycle op not done");
	a_flag_keep: assert property (tk && op_i inside {RRS_OP_ROTATE_LEFT, RRS_OP_ROTATE_RIGHT} |=>
		$stable(zero_o) && $stable(digit_carry_flag_o)) else $error("rotate touched other flags");
endmodule

bind rrs_exec rrs_exec_sva u_sva (.*);

//--- tb/rrs_exec_bench.sv
// Self-checking bench for the return, rotate and subtract unit
module rrs_exec_bench
	import rrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus, all set at time zero
	logic        ref_clk_i = 1'h0;
	logic        rstn_i = 1'h0;
	logic        issue_i = 1'h0;
	logic        dest_sel_i = 1'h0;
	rrs_op_t     op_i = RRS_OP_NONE;
	logic [7:0]  literal_i = 8'h00;
	logic [7:0]  file_rdata_i = 8'h00;
	logic [6:0]  file_addr_i = 7'h00;
	logic [14:0] stack_top_entry_i = 15'h0000;
	// Observed
	logic [7:0]  work_o, file_wdata_o;
	logic [6:0]  file_waddr_o;
	logic [14:0] pc_o;
	logic        carry_o, digit_carry_flag_o, zero_o, file_we_o, stack_pop_o, pc_load_o, busy_o, done_o;
	int          err_count = 0;
	int          n_compared = 0;
	// Packed views: done, carry, digit carry, zero, work / write / flow pulses
	wire [15:0]  st = {4'h0, done_o, carry_o, digit_carry_flag_o, zero_o, work_o};
	wire [15:0]  fw = {file_we_o, file_waddr_o, file_wdata_o};
	wire [15:0]  fl = {12'h000, stack_pop_o, pc_load_o, busy_o, done_o};

	rrs_exec u_dut (.*);

	always #2.5 ref_clk_i = ~ref_clk_i;

	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Issue stays high so callers may chain ops back to back
	task go(input rrs_op_t o, input logic [7:0] k, input logic [7:0] f, input logic d);
		issue_i = 1'h1;
		op_i = o;
		literal_i = k;
		file_rdata_i = f;
		file_addr_i = f[6:0];
		dest_sel_i = d;
		@(posedge ref_clk_i);
		#1;
	endtask

	task t_ret;
		stack_top_entry_i = 15'h7FFF;
		go(RRS_OP_RETURN, 8'h00, 8'h00, 1'h0);
		chk({1'h0, pc_o}, 16'h7FFF);
		chk(fl, 16'h000E);
		// A rotate offered while busy must be dropped
		op_i = RRS_OP_ROTATE_LEFT;
		dest_sel_i = 1'h1;
		@(posedge ref_clk_i);
		#1 issue_i = 1'h0;
		chk({fl[14:1], file_we_o, fl[0]}, 16'h0001);
		$display("return test done");
	endtask

	task t_lit(input logic [7:0] k, input logic [14:0] t);
		stack_top_entry_i = t;
		go(RRS_OP_LITERAL_RETURN, k, 8'h00, 1'h0);
		issue_i = 1'h0;
		chk({8'h00, work_o}, {8'h00, k});
		chk({1'h0, pc_o}, {1'h0, t});
		@(posedge ref_clk_i);
		#1 chk(fl, 16'h0001);
		$display("literal return test done");
	endtask

	task t_sub(input logic [7:0] k);
		logic [7:0] w;
		w = work_o;
		go(RRS_OP_LITERAL_MINUS_WORK, k, 8'h00, 1'h0);
		chk(st, {4'h0, 1'h1, w <= k, w[3:0] <= k[3:0], k == w, k - w});
		$display("subtract test done");
	endtask

	task t_rot(input rrs_op_t o, input logic [7:0] f, input logic d);
		logic [15:0] q;
		logic [7:0]  r;
		logic        lf;
		q = st;
		lf = o == RRS_OP_ROTATE_LEFT;
		r = lf ? {f[6:0], q[10]} : {q[10], f[7:1]};
		go(o, 8'h00, f, d);
		chk({12'h000, st[11:8]}, {12'h000, 1'h1, lf ? f[7] : f[0], q[9:8]});
		chk({8'h00, work_o}, {8'h00, d ? q[7:0] : r});
		chk(d ? fw : {fw[15], 15'h0000}, {d, d ? {f[6:0], r} : 15'h0000});
		$display("rotate test done");
	endtask

	task end_sim;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence; subtracts and rotates run back to back
	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1 rstn_i = 1'h1;
		t_ret;
		t_lit(8'hFF, 15'h2A55);
		t_lit(8'h07, 15'h0001);
		t_sub(8'h05);
		t_sub(8'hFE);
		t_sub(8'h10);
		t_sub(8'h0F);
		t_rot(RRS_OP_ROTATE_LEFT, 8'hE6, 1'h0);
		t_rot(RRS_OP_ROTATE_LEFT, 8'h01, 1'h1);
		t_rot(RRS_OP_ROTATE_RIGHT, 8'h01, 1'h0);
		t_rot(RRS_OP_ROTATE_RIGHT, 8'h80, 1'h1);
		issue_i = 1'h0;
		@(posedge ref_clk_i);
		end_sim;
	end

	// Watchdog: tests need about 18 cycles
	initial begin
		#5000;
		err_count++;
		end_sim;
	end
endmodule
